//--- verilog/sto_pkg.sv
`default_nettype none
package sto_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TEST_OFF_NS = 5_000_000;
  localparam int TEST_OFF_CYC = TEST_OFF_NS / CLK_PERIOD_NS;
  localparam int RESTART_WAIT_NS = 200_000_000;
  localparam int RESTART_WAIT_CYC = RESTART_WAIT_NS / CLK_PERIOD_NS;
  localparam int DISC_TOL_CYC_DEF = 40_000;
  localparam int TEST_ITV_CYC_DEF = 400_000_000;
  localparam int ACK_PULSE_CYC = 4;

  // ****************************************
  // Fault values
  // ****************************************
  localparam logic [15:0] FV_NONE = 16'h0000;
  localparam logic [15:0] FV_DISC_A = 16'h07D0;
  localparam logic [15:0] FV_DISC_B = 16'h07D2;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {CFG_BASIC, CFG_EXT, CFG_PMT} sto_cfg_e;
  typedef enum logic [1:0] {TSM_1, TSM_2, TSM_3, TSM_4} sto_tsm_e;
  typedef enum logic [1:0] {TST_IDLE, TST_RUN, TST_DONE} sto_tst_e;
  typedef enum logic [2:0] {
    CS_IDLE, CS_TEST, CS_TWAIT, CS_CHECK, CS_SACK, CS_SGAP, CS_STD, CS_DROP
  } sto_seq_e;

  // ****************************************
  // Controller register map
  // ****************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_FAULT = 4'hC;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_COAST_N = 1;
  localparam int CTRL_QUICK_N = 2;
  localparam int CTRL_BUS_STO = 3;
  localparam int CTRL_SEL_A = 4;
  localparam int CTRL_SEL_B = 5;
  localparam int CTRL_SPEED0 = 6;
  localparam int CTRL_STANDSTILL = 7;
  localparam int CTRL_AUTO = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h006;
  localparam int CMD_TEST = 0;
  localparam int CMD_ACK = 1;
  localparam int STATUS_W = 15;
endpackage : sto_pkg
`default_nettype wire

//--- verilog/sto_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sto_link_if;
  // Controller to device
  logic fsi_a;
  logic fsi_b;
  logic bus_sto_select;
  logic run_command;
  logic coast_stop_command_n;
  logic quick_stop_command_n;
  logic output_test_start;
  logic safe_acknowledge_flag;
  logic standard_acknowledge;
  // Device to controller
  logic torque_off_active_basic_flag;
  logic torque_off_deselect_basic_flag;
  logic torque_off_active_extended_flag;
  logic torque_off_deselect_extended_flag;
  logic ready_to_switch_on_flag;
  logic safety_internal_event_flag;
  logic test_required_extended_flag;
  logic test_busy;
  logic test_fail;
  logic discrepancy_fault;
  logic [15:0] fault_value;

  modport device (
    input fsi_a, fsi_b, bus_sto_select, run_command, coast_stop_command_n,
    quick_stop_command_n, output_test_start, safe_acknowledge_flag,
    standard_acknowledge,
    output torque_off_active_basic_flag, torque_off_deselect_basic_flag,
    torque_off_active_extended_flag, torque_off_deselect_extended_flag,
    ready_to_switch_on_flag, safety_internal_event_flag,
    test_required_extended_flag, test_busy, test_fail, discrepancy_fault,
    fault_value
  );
  modport ctrl (
    output fsi_a, fsi_b, bus_sto_select, run_command, coast_stop_command_n,
    quick_stop_command_n, output_test_start, safe_acknowledge_flag,
    standard_acknowledge,
    input torque_off_active_basic_flag, torque_off_deselect_basic_flag,
    torque_off_active_extended_flag, torque_off_deselect_extended_flag,
    ready_to_switch_on_flag, safety_internal_event_flag,
    test_required_extended_flag, test_busy, test_fail, discrepancy_fault,
    fault_value
  );
endinterface : sto_link_if
`default_nettype wire

//--- verilog/sto_device.sv
// Operation
// - Time output test interval, raise alarm
// - Controller starts test once alarm raised
// - Controller requests test only with run
// - Test drives output off, checks actuator
// - Controller drops start, confirms alarm cleared
// - Four selectable test-stop modes, three output shapes
// - STO active ignores run rising edge
// - STO active keeps motor off, stops ignored
// - No STO restriction when STO inactive
// - Input or telegram selection removes torque
// - Publish STO, deselect and ready flags
// - Restart waits for ready or delay
// - Basic discrepancy raises fault 2000/2002
// - Basic discrepancy sets internal event flag
// - Discrepant input evaluates zero until acknowledged
// - Discrepancy response chosen per configuration
// - Safe acknowledge by pulse or reselection
// - Standard acknowledge, drop run, reassert
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sto_device #(
  parameter int DISC_TOL_CYC = sto_pkg::DISC_TOL_CYC_DEF,
  parameter int TEST_ITV_CYC = sto_pkg::TEST_ITV_CYC_DEF,
  parameter int TEST_OFF_CYC = sto_pkg::TEST_OFF_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Link to the safety controller
  sto_link_if.device LINK,
  // Configuration, same clock domain
  input wire sto_pkg::sto_cfg_e CFG_MODE,
  input wire sto_pkg::sto_tsm_e TEST_STOP_MODE,
  // Plant
  input wire logic ACTUATOR_FB,
  output logic MOTOR_ON,
  output logic TORQUE_EN,
  output logic FS_OUTPUT
);

  typedef struct packed {
    logic fb_s1;
    logic fb_s2;
    logic run_q;
    logic start_q;
    logic ack_q;
    logic bsel_q;
    logic sto_act;
    logic motor_on;
    logic torque_en;
    logic fs_out;
    logic ready;
    logic disc_latch;
    logic disc_fault;
    logic event_flag;
    logic fault_pend;
    logic [15:0] fault_value;
    logic [31:0] disc_cnt;
    logic [31:0] itv_cnt;
    logic [31:0] tcnt;
    logic test_req;
    logic test_fail;
    sto_pkg::sto_tst_e tst;
  } sto_dev_s;

  sto_dev_s r;
  sto_dev_s next_r;
  logic mism;
  logic ack_evt;
  logic disc_set;
  logic sto_sel;
  logic test_off;
  logic chk_now;
  logic fb_exp;
  logic [31:0] half;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r = r;
    half = 32'(TEST_OFF_CYC / 2);
    test_off = 1'b0;
    chk_now = 1'b0;
    fb_exp = 1'b0;
    next_r.fb_s1 = ACTUATOR_FB;
    next_r.fb_s2 = r.fb_s1;
    next_r.run_q = LINK.run_command;
    next_r.start_q = LINK.output_test_start;
    next_r.ack_q = LINK.safe_acknowledge_flag;
    next_r.bsel_q = LINK.bus_sto_select;

    // Discrepancy between the two input channels
    mism = LINK.fsi_a ^ LINK.fsi_b;
    disc_set = mism & ~r.disc_latch
      & (r.disc_cnt >= 32'(DISC_TOL_CYC - 1));
    next_r.disc_cnt = (mism & ~r.disc_latch) ? r.disc_cnt + 32'h1 : 32'h0;
    ack_evt = (r.ack_q & ~LINK.safe_acknowledge_flag)
      | (r.bsel_q & ~LINK.bus_sto_select);
    if (ack_evt)
    begin
      next_r.disc_latch = 1'b0;
      next_r.event_flag = 1'b0;
    end
    if (LINK.standard_acknowledge & ~r.disc_latch & ~disc_set)
    begin
      next_r.fault_pend = 1'b0;
      next_r.disc_fault = 1'b0;
      next_r.fault_value = sto_pkg::FV_NONE;
    end
    // A new discrepancy wins over any acknowledge in the same cycle
    if (disc_set)
    begin
      next_r.disc_latch = 1'b1;
      next_r.disc_fault = 1'b1;
      next_r.fault_pend = 1'b1;
      unique case (CFG_MODE)
        sto_pkg::CFG_BASIC:
        begin
          next_r.fault_value = LINK.fsi_a ? sto_pkg::FV_DISC_B
            : sto_pkg::FV_DISC_A;
          next_r.event_flag = 1'b1;
        end
        sto_pkg::CFG_EXT:
          next_r.fault_value = sto_pkg::FV_NONE;
        sto_pkg::CFG_PMT:
        begin
          next_r.fault_value = sto_pkg::FV_NONE;
          next_r.event_flag = 1'b1;
        end
        default:
          next_r.event_flag = 1'b1;
      endcase
    end

    // Selection by either channel low, a latched input or the telegram
    sto_sel = ~(LINK.fsi_a & LINK.fsi_b & ~next_r.disc_latch)
      | LINK.bus_sto_select;
    next_r.sto_act = sto_sel;

    // Motor switching
    if (sto_sel | next_r.fault_pend)
      next_r.motor_on = 1'b0;
    else if (~LINK.run_command | ~LINK.coast_stop_command_n
      | ~LINK.quick_stop_command_n)
      next_r.motor_on = 1'b0;
    else if (LINK.run_command & ~r.run_q)
      next_r.motor_on = 1'b1;
    next_r.torque_en = next_r.motor_on & ~sto_sel;
    next_r.ready = ~sto_sel & ~next_r.fault_pend & ~next_r.motor_on;

    // Monitoring interval
    if (~r.test_req)
    begin
      next_r.itv_cnt = r.itv_cnt + 32'h1;
      if (r.itv_cnt >= 32'(TEST_ITV_CYC - 1))
        next_r.test_req = 1'b1;
    end

    // Forced output test
    unique case (r.tst)
      sto_pkg::TST_IDLE:
      begin
        if (LINK.output_test_start & ~r.start_q & LINK.run_command & ~sto_sel)
        begin
          next_r.tst = sto_pkg::TST_RUN;
          next_r.tcnt = 32'h0;
          next_r.test_fail = 1'b0;
        end
      end
      sto_pkg::TST_RUN:
      begin
        unique case (TEST_STOP_MODE)
          sto_pkg::TSM_1:
          begin
            test_off = 1'b1;
            chk_now = r.tcnt == 32'(TEST_OFF_CYC - 1);
          end
          sto_pkg::TSM_2:
          begin
            test_off = r.tcnt < half;
            chk_now = r.tcnt == half - 32'h1;
          end
          sto_pkg::TSM_3:
          begin
            test_off = r.tcnt >= half;
            chk_now = r.tcnt == 32'(TEST_OFF_CYC - 1);
          end
          sto_pkg::TSM_4:
          begin
            test_off = 1'b1;
            fb_exp = 1'b1;
            chk_now = r.tcnt == 32'(TEST_OFF_CYC - 1);
          end
        endcase
        if (chk_now & (r.fb_s2 != fb_exp))
          next_r.test_fail = 1'b1;
        next_r.tcnt = r.tcnt + 32'h1;
        if (r.tcnt == 32'(TEST_OFF_CYC - 1))
        begin
          next_r.tst = sto_pkg::TST_DONE;
          if (~next_r.test_fail)
          begin
            next_r.test_req = 1'b0;
            next_r.itv_cnt = 32'h0;
          end
        end
      end
      sto_pkg::TST_DONE:
      begin
        if (~LINK.output_test_start)
          next_r.tst = sto_pkg::TST_IDLE;
      end
      default:
      begin
        next_r.tst = sto_pkg::TST_IDLE;
      end
    endcase
    next_r.fs_out = ~(test_off & (r.tcnt != 32'(TEST_OFF_CYC - 1)))
      & ~next_r.event_flag;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      r <= '0;
      r.sto_act <= 1'b1;
      r.fs_out <= 1'b1;
      r.fault_value <= sto_pkg::FV_NONE;
      r.tst <= sto_pkg::TST_IDLE;
    end
    else
      r <= next_r;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign MOTOR_ON = r.motor_on;
  assign TORQUE_EN = r.torque_en;
  assign FS_OUTPUT = r.fs_out;
  assign LINK.torque_off_active_basic_flag = r.sto_act;
  assign LINK.torque_off_deselect_basic_flag = ~r.sto_act;
  assign LINK.torque_off_active_extended_flag =
    r.sto_act & (CFG_MODE == sto_pkg::CFG_EXT);
  assign LINK.torque_off_deselect_extended_flag =
    ~r.sto_act & (CFG_MODE == sto_pkg::CFG_EXT);
  assign LINK.ready_to_switch_on_flag = r.ready;
  assign LINK.safety_internal_event_flag = r.event_flag;
  assign LINK.test_required_extended_flag = r.test_req;
  assign LINK.test_busy = r.tst == sto_pkg::TST_RUN;
  assign LINK.test_fail = r.test_fail;
  assign LINK.discrepancy_fault = r.disc_fault;
  assign LINK.fault_value = r.fault_value;

endmodule : sto_device
`default_nettype wire

//--- verilog/sto_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sto_ctrl #(
  parameter int RESTART_WAIT_CYC = sto_pkg::RESTART_WAIT_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Link to the device
  sto_link_if.ctrl LINK,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Speed setpoint is zero
  output logic SPEED_ZERO
);

  typedef struct packed {
    logic [sto_pkg::CTRL_W-1:0] ctrl;
    logic [31:0] rdata;
    sto_pkg::sto_seq_e seq;
    logic [31:0] cnt;
    logic [31:0] wcnt;
    logic allowed;
    logic test_ok;
    logic run;
    logic fsa;
    logic fsb;
    logic start;
    logic sack;
    logic sstd;
  } sto_ctl_s;

  sto_ctl_s r;
  sto_ctl_s next_r;
  logic cmd_test;
  logic cmd_ack;
  logic [sto_pkg::STATUS_W-1:0] status;
  logic last;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r = r;
    last = r.cnt == 32'(sto_pkg::ACK_PULSE_CYC - 1);
    cmd_test = WR & (ADDR == sto_pkg::REG_CMD) & WDATA[sto_pkg::CMD_TEST];
    cmd_ack = WR & (ADDR == sto_pkg::REG_CMD) & WDATA[sto_pkg::CMD_ACK];
    if (WR & (ADDR == sto_pkg::REG_CTRL))
      next_r.ctrl = WDATA[sto_pkg::CTRL_W-1:0];

    // Restart gate after deselection
    if (LINK.torque_off_active_basic_flag)
    begin
      next_r.allowed = 1'b0;
      next_r.wcnt = 32'h0;
    end
    else if (~r.allowed)
    begin
      next_r.wcnt = r.wcnt + 32'h1;
      if (LINK.ready_to_switch_on_flag
        | (r.wcnt >= 32'(RESTART_WAIT_CYC - 1)))
        next_r.allowed = 1'b1;
    end

    next_r.cnt = r.cnt + 32'h1;
    unique case (r.seq)
      sto_pkg::CS_IDLE:
      begin
        next_r.cnt = 32'h0;
        if (cmd_ack)
        begin
          next_r.seq = sto_pkg::CS_SACK;
          next_r.sack = 1'b1;
        end
        else if ((cmd_test | (r.ctrl[sto_pkg::CTRL_AUTO]
          & LINK.test_required_extended_flag))
          & r.run & ~LINK.torque_off_active_basic_flag
          & (~r.ctrl[sto_pkg::CTRL_STANDSTILL]
          | r.ctrl[sto_pkg::CTRL_SPEED0]))
        begin
          next_r.seq = sto_pkg::CS_TEST;
          next_r.start = 1'b1;
        end
      end
      sto_pkg::CS_TEST:
      begin
        if (LINK.test_busy)
          next_r.seq = sto_pkg::CS_TWAIT;
        else if (~r.run | LINK.torque_off_active_basic_flag)
        begin
          next_r.start = 1'b0;
          next_r.seq = sto_pkg::CS_IDLE;
        end
      end
      sto_pkg::CS_TWAIT:
      begin
        if (~LINK.test_busy)
        begin
          next_r.start = 1'b0;
          next_r.seq = sto_pkg::CS_CHECK;
        end
      end
      sto_pkg::CS_CHECK:
      begin
        next_r.test_ok = ~LINK.test_required_extended_flag;
        next_r.seq = sto_pkg::CS_IDLE;
      end
      sto_pkg::CS_SACK:
      begin
        if (last)
        begin
          next_r.sack = 1'b0;
          next_r.cnt = 32'h0;
          next_r.seq = sto_pkg::CS_SGAP;
        end
      end
      sto_pkg::CS_SGAP:
      begin
        if (last)
        begin
          next_r.sstd = 1'b1;
          next_r.seq = sto_pkg::CS_STD;
        end
      end
      sto_pkg::CS_STD:
      begin
        next_r.sstd = 1'b0;
        next_r.cnt = 32'h0;
        next_r.seq = sto_pkg::CS_DROP;
      end
      sto_pkg::CS_DROP:
      begin
        if (last)
          next_r.seq = sto_pkg::CS_IDLE;
      end
      default:
      begin
        next_r.seq = sto_pkg::CS_IDLE;
      end
    endcase

    next_r.run = next_r.ctrl[sto_pkg::CTRL_RUN] & next_r.allowed
      & (next_r.seq != sto_pkg::CS_DROP);
    next_r.fsa = ~next_r.ctrl[sto_pkg::CTRL_SEL_A];
    next_r.fsb = ~next_r.ctrl[sto_pkg::CTRL_SEL_B];

    // Register reads
    status = {LINK.test_fail, LINK.discrepancy_fault,
      r.seq != sto_pkg::CS_IDLE, r.allowed, r.test_ok, LINK.test_busy,
      LINK.test_required_extended_flag, LINK.safety_internal_event_flag,
      LINK.ready_to_switch_on_flag, LINK.torque_off_deselect_extended_flag,
      LINK.torque_off_active_extended_flag,
      LINK.torque_off_deselect_basic_flag,
      LINK.torque_off_active_basic_flag, r.run, r.start};
    next_r.rdata = 32'h0;
    if (RD)
    begin
      unique case (ADDR)
        sto_pkg::REG_CTRL: next_r.rdata = 32'(r.ctrl);
        sto_pkg::REG_STATUS: next_r.rdata = 32'(status);
        sto_pkg::REG_FAULT: next_r.rdata = 32'(LINK.fault_value);
        default: next_r.rdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      r <= '0;
      r.ctrl <= sto_pkg::CTRL_RST;
      r.seq <= sto_pkg::CS_IDLE;
      r.fsa <= 1'b1;
      r.fsb <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA = r.rdata;
  assign SPEED_ZERO = r.ctrl[sto_pkg::CTRL_SPEED0];
  assign LINK.fsi_a = r.fsa;
  assign LINK.fsi_b = r.fsb;
  assign LINK.bus_sto_select = r.ctrl[sto_pkg::CTRL_BUS_STO];
  assign LINK.run_command = r.run;
  assign LINK.coast_stop_command_n = r.ctrl[sto_pkg::CTRL_COAST_N];
  assign LINK.quick_stop_command_n = r.ctrl[sto_pkg::CTRL_QUICK_N];
  assign LINK.output_test_start = r.start;
  assign LINK.safe_acknowledge_flag = r.sack;
  assign LINK.standard_acknowledge = r.sstd;

endmodule : sto_ctrl
`default_nettype wire

//--- verif/sto_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sto_link_monitor #(
  parameter int TEST_ITV_CYC = sto_pkg::TEST_ITV_CYC_DEF
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Controller to device
  input wire logic fsi_a,
  input wire logic fsi_b,
  input wire logic bus_sto_select,
  input wire logic run_command,
  input wire logic output_test_start,
  input wire logic safe_acknowledge_flag,
  input wire logic standard_acknowledge,
  // Device to controller
  input wire logic torque_off_active_basic_flag,
  input wire logic torque_off_deselect_basic_flag,
  input wire logic ready_to_switch_on_flag,
  input wire logic safety_internal_event_flag,
  input wire logic test_required_extended_flag,
  input wire logic test_busy,
  input wire logic discrepancy_fault,
  input wire logic [15:0] fault_value
);
  int itv_cnt;
  logic busy_q;

  // ****************************************
  // Cycles since reset or since the last test ended
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      itv_cnt <= 0;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= test_busy;
      if (busy_q && !test_busy)
        itv_cnt <= 0;
      else
        itv_cnt <= itv_cnt + 1;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  property p_sel;
    (!fsi_a || !fsi_b || bus_sto_select) |=> torque_off_active_basic_flag;
  endproperty
  a_sel: assert property (p_sel)
    else $error("torque off not active after select");
  property p_desel;
    torque_off_deselect_basic_flag == !torque_off_active_basic_flag;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect flag not inverse of active flag");
  property p_ready;
    torque_off_active_basic_flag [*2] |-> !ready_to_switch_on_flag;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag set while torque off active");
  property p_evt;
    $rose(discrepancy_fault) && fault_value != sto_pkg::FV_NONE
      |-> safety_internal_event_flag;
  endproperty
  a_evt: assert property (p_evt)
    else $error("discrepancy without internal event");
  property p_tst_go;
    $rose(test_busy)
      |-> $past(run_command) && !$past(torque_off_active_basic_flag);
  endproperty
  a_tst_go: assert property (p_tst_go)
    else $error("output test began without run or under torque off");
  property p_tst_len;
    $rose(test_busy) |-> test_busy [*8] ##[1:24] !test_busy;
  endproperty
  a_tst_len: assert property (p_tst_len)
    else $error("output test length wrong");
  property p_alm_clr;
    $fell(test_required_extended_flag)
      |-> $past(test_busy) || $past(test_busy, 2);
  endproperty
  a_alm_clr: assert property (p_alm_clr)
    else $error("test alarm cleared without a test");
  property p_alm_itv;
    $rose(test_required_extended_flag)
      |-> itv_cnt >= TEST_ITV_CYC - 4 && itv_cnt <= TEST_ITV_CYC + 4;
  endproperty
  a_alm_itv: assert property (p_alm_itv)
    else $error("test alarm raised at wrong time");
  property p_sack;
    $rose(safe_acknowledge_flag)
      |-> safe_acknowledge_flag [*4] ##1 !safe_acknowledge_flag;
  endproperty
  a_sack: assert property (p_sack)
    else $error("safe acknowledge pulse length wrong");
  property p_std;
    $fell(safe_acknowledge_flag) |-> ##[1:8] standard_acknowledge;
  endproperty
  a_std: assert property (p_std)
    else $error("standard acknowledge missing after safe acknowledge");
  property p_drop;
    $fell(test_busy) |-> ##[0:4] !output_test_start;
  endproperty
  a_drop: assert property (p_drop)
    else $error("test start not dropped after test");

  c_disc: cover property ($rose(discrepancy_fault));
  c_pass: cover property ($fell(test_required_extended_flag));
  c_sto: cover property ($rose(torque_off_active_basic_flag));
endmodule : sto_link_monitor
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys;
  logic rstn;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] rdata;
  logic act_fb;
  logic stuck;
  logic motor_on;
  logic torque_en;
  logic fs_output;
  sto_pkg::sto_cfg_e cfg_mode;
  sto_pkg::sto_tsm_e tsm;
  int err_total;
  int total_checks;
  logic [31:0] d;
  logic [31:0] sel_tab [3];
  logic [15:0] fv_tab [3];

  // ****************************************
  // Design and monitor
  // ****************************************
  sto_link_if u_sto_link_if();
  sto_device #(.DISC_TOL_CYC(8), .TEST_ITV_CYC(50), .TEST_OFF_CYC(16))
    u_sto_device (.CLK_SYS(clk_sys), .RSTN(rstn), .LINK(u_sto_link_if.device),
    .CFG_MODE(cfg_mode), .TEST_STOP_MODE(tsm), .ACTUATOR_FB(act_fb),
    .MOTOR_ON(motor_on), .TORQUE_EN(torque_en), .FS_OUTPUT(fs_output));
  sto_ctrl #(.RESTART_WAIT_CYC(20)) u_sto_ctrl (.CLK_SYS(clk_sys),
    .RSTN(rstn), .LINK(u_sto_link_if.ctrl), .ADDR(addr), .WDATA(wdata),
    .WR(reg_wr), .RD(reg_rd), .RDATA(rdata), .SPEED_ZERO());
  sto_link_monitor #(.TEST_ITV_CYC(50)) u_sto_link_monitor (
    .CLK_SYS(clk_sys), .RSTN(rstn), .fsi_a(u_sto_link_if.fsi_a),
    .fsi_b(u_sto_link_if.fsi_b),
    .bus_sto_select(u_sto_link_if.bus_sto_select),
    .run_command(u_sto_link_if.run_command),
    .output_test_start(u_sto_link_if.output_test_start),
    .safe_acknowledge_flag(u_sto_link_if.safe_acknowledge_flag),
    .standard_acknowledge(u_sto_link_if.standard_acknowledge),
    .torque_off_active_basic_flag(u_sto_link_if.torque_off_active_basic_flag),
    .torque_off_deselect_basic_flag(
      u_sto_link_if.torque_off_deselect_basic_flag),
    .ready_to_switch_on_flag(u_sto_link_if.ready_to_switch_on_flag),
    .safety_internal_event_flag(u_sto_link_if.safety_internal_event_flag),
    .test_required_extended_flag(u_sto_link_if.test_required_extended_flag),
    .test_busy(u_sto_link_if.test_busy),
    .discrepancy_fault(u_sto_link_if.discrepancy_fault),
    .fault_value(u_sto_link_if.fault_value));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Actuator follows the output; inverted contact in mode 4
  always @(posedge clk_sys)
    act_fb <= stuck | (fs_output ^ (tsm == sto_pkg::TSM_4));

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = rdata;
  endtask : bus_rd

  task wait_st(input int b, input logic v);
    int n;
    n = 0;
    bus_rd(sto_pkg::REG_STATUS, d);
    while (d[b] !== v && n < 200)
    begin
      bus_rd(sto_pkg::REG_STATUS, d);
      n++;
    end
    if (n >= 200)
    begin
      err_total++;
      $display("unexpected timeout on status bit %0d", b);
      final_report();
    end
  endtask : wait_st

  task wait_motor;
    int n;
    n = 0;
    @(negedge clk_sys);
    while (motor_on !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("motor_on_rise", motor_on, 1'b1);
    if (motor_on !== 1'b1)
      final_report();
  endtask : wait_motor

  task do_test(input sto_pkg::sto_tsm_e m, input logic pass);
    int low;
    int exp;
    low = 0;
    exp = (m == sto_pkg::TSM_2 || m == sto_pkg::TSM_3) ? 8 : 16;
    @(posedge clk_sys);
    tsm <= m;
    wait_st(8, 1'b1);
    bus_wr(sto_pkg::REG_CMD, 32'h0000_0001);
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clk_sys);
      if (fs_output === 1'b0)
        low++;
      if (i > 3 && u_sto_link_if.test_busy !== 1'b1)
        break;
    end
    chk("fs_off_cycles", 32'(low >= exp - 2 && low <= exp + 1), 1);
    bus_rd(sto_pkg::REG_STATUS, d);
    chk("test_alarm", d[8], !pass);
    chk("test_fail", d[14], !pass);
  endtask : do_test

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    rstn = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    stuck = 1'b0;
    cfg_mode = sto_pkg::CFG_BASIC;
    tsm = sto_pkg::TSM_1;
    err_total = 0;
    total_checks = 0;
    sel_tab = '{32'h10, 32'h20, 32'h10};
    fv_tab = '{sto_pkg::FV_DISC_A, sto_pkg::FV_DISC_B, sto_pkg::FV_NONE};
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bus_rd(sto_pkg::REG_STATUS, d);
    chk("status_idle", d[8:2], 7'h12);
    bus_wr(4'h6, 32'hFF);
    bus_rd(sto_pkg::REG_CTRL, d);
    chk("ctrl_reset", d, 32'h006);
    bus_rd(4'h2, d);
    chk("unmapped", d, 32'h0);
    $display("test reset done");
    foreach (sel_tab[i])
    begin
      bus_wr(sto_pkg::REG_CTRL, 32'h006);
      bus_wr(sto_pkg::REG_CTRL, 32'h007);
      wait_motor();
      bus_wr(sto_pkg::REG_CTRL, 32'h005 - 32'(i * 2));
      repeat (3) @(negedge clk_sys);
      chk("stop_cmd", motor_on, 1'b0);
    end
    $display("test run and stop done");
    foreach (sel_tab[i])
    begin
      bus_wr(sto_pkg::REG_CTRL, 32'h006);
      bus_wr(sto_pkg::REG_CTRL, 32'h007);
      wait_motor();
      bus_wr(sto_pkg::REG_CTRL, 32'h007 | (i == 0 ? 32'h30 : 32'h08));
      repeat (3) @(negedge clk_sys);
      chk("torque_sto", {motor_on, torque_en}, 2'b00);
      bus_rd(sto_pkg::REG_STATUS, d);
      chk("sto_flags", d[3:2], 2'b01);
      bus_wr(sto_pkg::REG_CTRL, 32'h006);
      bus_wr(sto_pkg::REG_CTRL, 32'h007 | (i == 0 ? 32'h30 : 32'h08));
      repeat (2) @(negedge clk_sys);
      chk("run_under_sto", motor_on, 1'b0);
      bus_wr(sto_pkg::REG_CTRL, 32'h006);
      wait_st(6, 1'b1);
      bus_wr(sto_pkg::REG_CTRL, 32'h007);
      wait_motor();
    end
    $display("test torque off done");
    for (int m = 0; m < 4; m++)
      do_test(sto_pkg::sto_tsm_e'(m), 1'b1);
    $display("test output test done");
    foreach (sel_tab[i])
    begin
      bus_wr(sto_pkg::REG_CTRL, 32'h007 | sel_tab[i]);
      cfg_mode <= sto_pkg::sto_cfg_e'(i / 2);
      repeat (12) @(posedge clk_sys);
      bus_rd(sto_pkg::REG_FAULT, d);
      chk("fault_value", d[15:0], fv_tab[i]);
      bus_rd(sto_pkg::REG_STATUS, d);
      chk("event_fault", {d[13], d[7]},
        {1'b1, cfg_mode == sto_pkg::CFG_BASIC});
      chk("ext_active", d[4], cfg_mode == sto_pkg::CFG_EXT);
      bus_wr(sto_pkg::REG_CTRL, 32'h006);
      repeat (6) @(posedge clk_sys);
      bus_rd(sto_pkg::REG_STATUS, d);
      chk("input_forced", d[2], 1'b1);
      bus_wr(sto_pkg::REG_CMD, 32'h0000_0002);
      wait_st(13, 1'b0);
      wait_st(2, 1'b0);
      bus_rd(sto_pkg::REG_FAULT, d);
      chk("fault_cleared", d[15:0], sto_pkg::FV_NONE);
    end
    $display("test discrepancy done");
    bus_wr(sto_pkg::REG_CTRL, 32'h007);
    wait_motor();
    stuck = 1'b1;
    do_test(sto_pkg::TSM_1, 1'b0);
    $display("test failed output test done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
